/* File: rtl/eipc_pkg.sv */
// constants for the external and pin-change interrupt unit
package eipc_pkg;
  // register byte addresses
  localparam logic [7:0] SENSE_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] ENABLE_MASK_ADDR   = 8'h04;
  localparam logic [7:0] IRQ_FLAGS_ADDR     = 8'h08;
  localparam logic [7:0] GROUP_ENABLE_ADDR  = 8'h0C;
  localparam logic [7:0] GROUP_FLAGS_ADDR   = 8'h10;
  localparam logic [7:0] GROUP0_MASK_ADDR   = 8'h14;
  localparam logic [7:0] GROUP1_MASK_ADDR   = 8'h18;
  localparam logic [7:0] GROUP2_MASK_ADDR   = 8'h1C;
  localparam logic [7:0] GROUP3_MASK_ADDR   = 8'h20;
  localparam logic [7:0] PIN_STATUS_ADDR    = 8'h24;

  // widths
  localparam int DED_PINS  = 4;
  localparam int PC_PINS   = 27;
  localparam int GROUPS    = 4;
  localparam int ADDR_W    = 8;

  // pin-change group boundaries
  localparam int G0_LO = 0;
  localparam int G0_HI = 7;
  localparam int G1_LO = 8;
  localparam int G1_HI = 15;
  localparam int G2_LO = 16;
  localparam int G2_HI = 23;
  localparam int G3_LO = 24;
  localparam int G3_HI = 26;

  // sense field encodings
  localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
  localparam logic [1:0] SENSE_ANY_EDGE  = 2'h1;
  localparam logic [1:0] SENSE_FALLING   = 2'h2;
  localparam logic [1:0] SENSE_RISING    = 2'h3;

  // reset values
  localparam logic [7:0] SENSE_CONTROL_RST = 8'h00;
  localparam logic [3:0] ENABLE_MASK_RST   = 4'h0;
  localparam logic [3:0] FLAGS_RST         = 4'h0;
  localparam logic [3:0] GROUP_ENABLE_RST  = 4'h0;
  localparam logic [26:0] PIN_MASK_RST     = 27'h000_0000;

  // synchroniser depth plus one prior sample before edges count
  localparam int PRIME_CYCLES = 3;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: rtl/eipc_sync.sv */
// two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ns
module eipc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      q_o  <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

/* File: rtl/eipc_top.sv */
// external interrupt pins and pin-change groups with an axi4-lite register slave
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Operation
// R1: pins raise interrupts whatever their direction, allowing software-made interrupts.
// R2: pin-change inputs form groups 3 (26..24), 2 (23..16), 1 (15..8), 0 (7..0).
// R3: pin-change events are seen without the clock for wake-up.
// R4: sense field 00 low level, 01 any change, 10 falling, 11 rising.
// R5: enabled low-level interrupt requests for as long as the pin stays low.
// R6: dedicated pin edges are recognised only while the clock runs.
// R7: low level on a dedicated pin is seen without the clock for wake-up.
// R8: level wake without held level wakes but raises no interrupt.
// R9: dedicated pins are sampled; edges come from comparing successive samples.
// R10: pulses longer than one clock in edge modes always set the flag.
// R11: source holds a low level until the current instruction completes.
// R12: software clears the enable before changing sense bits.
// R13: dedicated request needs its enable bit and the global interrupt flag.
// R14: dedicated flag sets on edge, clears on acknowledge or written one.
// R15: dedicated flag stays cleared while its sense is low level.
// R16: group request needs its group enable and the global interrupt flag.
// R17: group 3 flag sets on a change, clears on acknowledge or written one.
// R18: a pin counts only when its mask bit and group enable are set.
// R19: groups 2..0 flags set on a change, clear on acknowledge or written one.
// R20: pin events cross two flip-flops before touching readable flags.
// R21: one request line per interrupt, flag cleared by a one-cycle acknowledge.
module eipc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  dedicated_irq_pins_i,
  input  wire logic [26:0] pin_change_inputs_i,
  input  wire logic        cpu_global_irq_enable_i,
  input  wire logic [3:0]  dedicated_irq_ack_i,
  input  wire logic [3:0]  pin_change_group_ack_i,
  output logic      [3:0]  dedicated_irq_request_o,
  output logic             pin_change_group0_request_o,
  output logic             pin_change_group1_request_o,
  output logic             pin_change_group2_request_o,
  output logic             pin_change_group3_request_o,
  output logic             wake_o,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  logic [7:0]  sense_control;
  logic [3:0]  enable_mask;
  logic [3:0]  ded_flag;
  logic [3:0]  group_enable;
  logic [3:0]  group_flag;
  logic [26:0] pin_mask;
  logic [3:0]  ded_s;
  logic [3:0]  ded_p;
  logic [26:0] pc_s;
  logic [26:0] pc_p;
  logic [2:0]  prime;
  logic        primed;
  logic [3:0]  lvl_sel;
  logic [3:0]  ded_set;
  logic [26:0] pc_hit;
  logic [3:0]  grp_set;
  logic [26:0] grp_en_bits;
  logic [3:0]  grp_req;
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_wr;
  logic        wr_lane0;
  logic        wr_hit;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic [3:0]  next_ded_flag;
  logic [3:0]  next_group_flag;

  // pins are sampled through two flops; direction of the pin is not looked at [R1] [R20]
  eipc_sync #(.W(eipc_pkg::DED_PINS)) u_ded_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (dedicated_irq_pins_i),
    .q_o   (ded_s)
  );

  eipc_sync #(.W(eipc_pkg::PC_PINS)) u_pc_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (pin_change_inputs_i),
    .q_o   (pc_s)
  );

  // previous sample for edge compare; prime hides the false edge the reset zeros would make [R9]
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ded_p <= '0;
      pc_p  <= '0;
      prime <= '0;
    end
    else
    begin
      ded_p <= ded_s;
      pc_p  <= pc_s;
      prime <= {prime[1:0], 1'b1};
    end
  end
  assign primed = prime[eipc_pkg::PRIME_CYCLES-1];

  // sense decode per dedicated pin; edges need a running clock [R4] [R6] [R10]
  always_comb
  begin
    for (int i = 0; i < eipc_pkg::DED_PINS; i++)
    begin
      lvl_sel[i] = 1'b0;
      ded_set[i] = 1'b0;
      case (sense_control[2*i +: 2])
        eipc_pkg::SENSE_LOW_LEVEL: lvl_sel[i] = 1'b1;
        eipc_pkg::SENSE_ANY_EDGE:  ded_set[i] = primed & (ded_s[i] ^ ded_p[i]);
        eipc_pkg::SENSE_FALLING:   ded_set[i] = primed & ded_p[i] & ~ded_s[i];
        default:                   ded_set[i] = primed & ~ded_p[i] & ded_s[i];
      endcase
    end
  end

  // per-pin group enable spread so each pin sees its own group bit [R2] [R18]
  assign grp_en_bits = {{3{group_enable[3]}}, {8{group_enable[2]}}, {8{group_enable[1]}}, {8{group_enable[0]}}};
  assign pc_hit      = {27{primed}} & (pc_s ^ pc_p) & pin_mask & grp_en_bits; // [R18]
  assign grp_set[0]  = |pc_hit[eipc_pkg::G0_HI:eipc_pkg::G0_LO]; // [R19]
  assign grp_set[1]  = |pc_hit[eipc_pkg::G1_HI:eipc_pkg::G1_LO]; // [R19]
  assign grp_set[2]  = |pc_hit[eipc_pkg::G2_HI:eipc_pkg::G2_LO]; // [R19]
  assign grp_set[3]  = |pc_hit[eipc_pkg::G3_HI:eipc_pkg::G3_LO]; // [R17]

  // axi write channels accepted independently, in either order
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;
  assign do_wr         = aw_held & w_held & ~s_axi_bvalid;
  assign wr_lane0      = do_wr & w_strb[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (s_axi_awvalid && !aw_held)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_wr)
    begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (s_axi_wvalid && !w_held)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_wr)
    begin
      w_held <= 1'b0;
    end
  end

  always_comb
  begin
    if (aw_addr == eipc_pkg::SENSE_CONTROL_ADDR)
      wr_hit = 1'b1;
    else if (aw_addr == eipc_pkg::ENABLE_MASK_ADDR)
      wr_hit = 1'b1;
    else if (aw_addr == eipc_pkg::IRQ_FLAGS_ADDR)
      wr_hit = 1'b1;
    else if (aw_addr == eipc_pkg::GROUP_ENABLE_ADDR)
      wr_hit = 1'b1;
    else if (aw_addr == eipc_pkg::GROUP_FLAGS_ADDR)
      wr_hit = 1'b1;
    else if (aw_addr >= eipc_pkg::GROUP0_MASK_ADDR && aw_addr <= eipc_pkg::PIN_STATUS_ADDR && aw_addr[1:0] == 2'h0)
      wr_hit = 1'b1;
    else
      wr_hit = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= eipc_pkg::RESP_OKAY;
    end
    else if (do_wr)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? eipc_pkg::RESP_OKAY : eipc_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration registers; sense changes are not interlocked with the enable [R12]
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sense_control <= eipc_pkg::SENSE_CONTROL_RST;
      enable_mask   <= eipc_pkg::ENABLE_MASK_RST;
      group_enable  <= eipc_pkg::GROUP_ENABLE_RST;
      pin_mask      <= eipc_pkg::PIN_MASK_RST;
    end
    else if (wr_lane0)
    begin
      if (aw_addr == eipc_pkg::SENSE_CONTROL_ADDR)
        sense_control <= w_data[7:0];
      else if (aw_addr == eipc_pkg::ENABLE_MASK_ADDR)
        enable_mask <= w_data[3:0];
      else if (aw_addr == eipc_pkg::GROUP_ENABLE_ADDR)
        group_enable <= w_data[3:0];
      else if (aw_addr == eipc_pkg::GROUP0_MASK_ADDR)
        pin_mask[eipc_pkg::G0_HI:eipc_pkg::G0_LO] <= w_data[7:0];
      else if (aw_addr == eipc_pkg::GROUP1_MASK_ADDR)
        pin_mask[eipc_pkg::G1_HI:eipc_pkg::G1_LO] <= w_data[7:0];
      else if (aw_addr == eipc_pkg::GROUP2_MASK_ADDR)
        pin_mask[eipc_pkg::G2_HI:eipc_pkg::G2_LO] <= w_data[7:0];
      else if (aw_addr == eipc_pkg::GROUP3_MASK_ADDR)
        pin_mask[eipc_pkg::G3_HI:eipc_pkg::G3_LO] <= w_data[2:0];
    end
  end

  // flags: set beats acknowledge and write-one clear in the same cycle
  always_comb
  begin
    next_ded_flag   = ded_flag & ~dedicated_irq_ack_i; // [R14] [R21]
    next_group_flag = group_flag & ~pin_change_group_ack_i; // [R17] [R19] [R21]
    if (wr_lane0 && aw_addr == eipc_pkg::IRQ_FLAGS_ADDR)
      next_ded_flag = next_ded_flag & ~w_data[3:0]; // [R14]
    if (wr_lane0 && aw_addr == eipc_pkg::GROUP_FLAGS_ADDR)
      next_group_flag = next_group_flag & ~w_data[3:0]; // [R17] [R19]
    next_ded_flag   = (next_ded_flag | ded_set) & ~lvl_sel; // [R14] [R15]
    next_group_flag = next_group_flag | grp_set; // [R17] [R19]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ded_flag   <= eipc_pkg::FLAGS_RST;
      group_flag <= eipc_pkg::FLAGS_RST;
    end
    else
    begin
      ded_flag   <= next_ded_flag;
      group_flag <= next_group_flag;
    end
  end

  // level requests follow the synced pin, so a level gone before start-up gives none [R5] [R8] [R11] [R13]
  assign dedicated_irq_request_o = enable_mask & {4{cpu_global_irq_enable_i}} & ((lvl_sel & ~ded_s) | ded_flag);
  assign grp_req = group_enable & {4{cpu_global_irq_enable_i}} & group_flag; // [R16]
  assign pin_change_group0_request_o = grp_req[0];
  assign pin_change_group1_request_o = grp_req[1];
  assign pin_change_group2_request_o = grp_req[2];
  assign pin_change_group3_request_o = grp_req[3];

  // clockless wake: raw low level on a dedicated pin, or raw pin-change input against its last synced sample, works with the clock stopped [R3] [R7]
  assign wake_o = (|(enable_mask & lvl_sel & ~dedicated_irq_pins_i))
                | (|((pin_change_inputs_i ^ pc_s) & pin_mask & grp_en_bits));

  // read path
  assign s_axi_arready = ~s_axi_rvalid;

  always_comb
  begin
    rd_hit = 1'b1;
    if (s_axi_araddr == eipc_pkg::SENSE_CONTROL_ADDR)
      rd_mux = {24'h00_0000, sense_control};
    else if (s_axi_araddr == eipc_pkg::ENABLE_MASK_ADDR)
      rd_mux = {28'h000_0000, enable_mask};
    else if (s_axi_araddr == eipc_pkg::IRQ_FLAGS_ADDR)
      rd_mux = {28'h000_0000, ded_flag};
    else if (s_axi_araddr == eipc_pkg::GROUP_ENABLE_ADDR)
      rd_mux = {28'h000_0000, group_enable};
    else if (s_axi_araddr == eipc_pkg::GROUP_FLAGS_ADDR)
      rd_mux = {28'h000_0000, group_flag};
    else if (s_axi_araddr == eipc_pkg::GROUP0_MASK_ADDR)
      rd_mux = {24'h00_0000, pin_mask[eipc_pkg::G0_HI:eipc_pkg::G0_LO]};
    else if (s_axi_araddr == eipc_pkg::GROUP1_MASK_ADDR)
      rd_mux = {24'h00_0000, pin_mask[eipc_pkg::G1_HI:eipc_pkg::G1_LO]};
    else if (s_axi_araddr == eipc_pkg::GROUP2_MASK_ADDR)
      rd_mux = {24'h00_0000, pin_mask[eipc_pkg::G2_HI:eipc_pkg::G2_LO]};
    else if (s_axi_araddr == eipc_pkg::GROUP3_MASK_ADDR)
      rd_mux = {29'h0000_0000, pin_mask[eipc_pkg::G3_HI:eipc_pkg::G3_LO]};
    else if (s_axi_araddr == eipc_pkg::PIN_STATUS_ADDR)
      rd_mux = {1'b0, ded_s, pc_s};
    else
    begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= eipc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? eipc_pkg::RESP_OKAY : eipc_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_level_flag_clear: // [R15]
    assert property (1 |=> ((ded_flag & $past(lvl_sel)) == 4'h0))
      else $error("flag set while sense is low level");

  a_level_request: // [R5]
    assert property ((enable_mask[0] && cpu_global_irq_enable_i && lvl_sel[0] && !ded_s[0])
                     |-> dedicated_irq_request_o[0])
      else $error("low level did not request");

  a_edge_sets_flag: // [R14]
    assert property (ded_set[1] |=> ded_flag[1])
      else $error("edge lost before flag");

  a_ack_clears_flag: // [R21]
    assert property ((dedicated_irq_ack_i[2] && !ded_set[2]) |=> !ded_flag[2])
      else $error("acknowledge did not clear flag");

  a_global_gate: // [R13]
    assert property (!cpu_global_irq_enable_i |-> (dedicated_irq_request_o == 4'h0 && grp_req == 4'h0))
      else $error("request without global enable");

  a_pin_to_group: // [R19]
    assert property ((primed && group_enable[0] && pin_mask[0] && $rose(pc_s[0])) |=> group_flag[0])
      else $error("pin change missed by group 0");

  a_group_disabled: // [R18]
    assert property (!group_enable[3] |=> !$rose(group_flag[3]))
      else $error("disabled group set its flag");

  a_group3_pin: // [R17]
    assert property ((pin_mask[25] && group_enable[3] && primed && pc_s[25] != pc_p[25]) |=> group_flag[3])
      else $error("group 3 change missed");

  a_write_one_clear: // [R14]
    assert property ((wr_lane0 && aw_addr == eipc_pkg::IRQ_FLAGS_ADDR && w_data[0] && !ded_set[0])
                     |=> !ded_flag[0])
      else $error("write one did not clear flag");

  a_rising_only: // [R4]
    assert property ((primed && sense_control[1:0] == eipc_pkg::SENSE_RISING && $fell(ded_s[0])
                      && !ded_flag[0]) |=> !ded_flag[0])
      else $error("falling edge set a rising flag");

  a_write_answer:
    assert property (do_wr |=> s_axi_bvalid)
      else $error("write not answered");

  a_read_answer:
    assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
      else $error("read not answered");

  c_edge_request: cover property (ded_set[0] ##1 dedicated_irq_request_o[0]);
  c_level_request: cover property (lvl_sel[3] && dedicated_irq_request_o[3]);
  c_group_request: cover property (grp_set[2] ##1 pin_change_group2_request_o);
  c_wake: cover property (wake_o);
endmodule

/* File: test/eipc_board_model.sv */
// board pins and cpu interrupt core facing the interrupt unit
`timescale 1ns/1ns
module eipc_board_model (
  input  wire logic        clk_i,
  input  wire logic [3:0]  ded_cmd_i,
  input  wire logic [26:0] pc_cmd_i,
  input  wire logic        glob_cmd_i,
  input  wire logic        auto_ack_i,
  input  wire logic [3:0]  ded_req_i,
  input  wire logic [3:0]  grp_req_i,
  output logic      [3:0]  ded_pins_o,
  output logic      [26:0] pc_pins_o,
  output logic             glob_o,
  output logic      [3:0]  ded_ack_o,
  output logic      [3:0]  grp_ack_o
);
  initial
  begin
    ded_pins_o = 4'hf;
    pc_pins_o  = 27'h000_0000;
    glob_o     = 1'b0;
    ded_ack_o  = 4'h0;
    grp_ack_o  = 4'h0;
  end
  // levels move only on an edge and stand until told, so every pulse lasts whole cycles
  always @(posedge clk_i)
  begin
    ded_pins_o <= ded_cmd_i;
    pc_pins_o  <= pc_cmd_i;
    glob_o     <= glob_cmd_i;
  end
  // one-cycle acknowledge; a gap cycle lets the cleared flag drop the request first
  always @(posedge clk_i)
  begin
    ded_ack_o <= (auto_ack_i && ded_ack_o == 4'h0) ? ded_req_i : 4'h0;
    grp_ack_o <= (auto_ack_i && grp_ack_o == 4'h0) ? grp_req_i : 4'h0;
  end
endmodule

/* File: test/ext_and_pin_change_irq_tb.sv */
// self-checking bench for the external and pin-change interrupt unit
`timescale 1ns/1ns
module ext_and_pin_change_irq_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        glob = 1'b0;
  logic        auto_ack = 1'b0;
  logic [3:0]  ded_cmd = 4'hf;
  logic [26:0] pc_cmd = 27'h000_0000;
  logic [3:0]  ded_pins, ded_ack, ded_req, grp_ack;
  logic [26:0] pc_pins;
  logic        glob_q, wake_o, g0, g1, g2, g3;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          bad_count = 0, comparisons = 0, ack_seen = 0;
  wire  [3:0]  grp_req = {g3, g2, g1, g0};

  always #5 clk_i = ~clk_i;

  eipc_board_model u_board (.clk_i(clk_i), .ded_cmd_i(ded_cmd), .pc_cmd_i(pc_cmd), .glob_cmd_i(glob),
    .auto_ack_i(auto_ack), .ded_req_i(ded_req), .grp_req_i(grp_req), .ded_pins_o(ded_pins),
    .pc_pins_o(pc_pins), .glob_o(glob_q), .ded_ack_o(ded_ack), .grp_ack_o(grp_ack));

  eipc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .dedicated_irq_pins_i(ded_pins), .pin_change_inputs_i(pc_pins),
    .cpu_global_irq_enable_i(glob_q), .dedicated_irq_ack_i(ded_ack), .pin_change_group_ack_i(grp_ack),
    .dedicated_irq_request_o(ded_req), .pin_change_group0_request_o(g0), .pin_change_group1_request_o(g1),
    .pin_change_group2_request_o(g2), .pin_change_group3_request_o(g3), .wake_o(wake_o),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  always @(posedge clk_i)
    if (ded_ack != 4'h0 || grp_ack != 4'h0)
      ack_seen <= ack_seen + 1;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check(what, d, exp);
    check("read response", r, eipc_pkg::RESP_OKAY);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // the whole run needs about four hundred cycles; ten thousand means a hang
  initial
  begin
    #100000;
    bad_count++;
    finish_test();
  end

  initial
  begin
    int          n, md, ef, p, q, g, lo, sz;
    logic [31:0] d;
    logic [1:0]  r;
    void'($urandom(18477));
    cyc(4);
    rst_i <= 1'b0;
    cyc(eipc_pkg::PRIME_CYCLES + 1);
    for (n = 0; n < 9; n++)
      rchk(8'(4 * n), 32'h0000_0000, "reset value");
    rchk(eipc_pkg::PIN_STATUS_ADDR, 32'h7800_0000, "pin status");
    axi_rd(8'h28, d, r);
    check("unmapped read", {d[29:0], r}, 32'h0000_0002);
    axi_wr(8'h2c, 32'h0000_00ff, r);
    check("unmapped write", r, eipc_pkg::RESP_SLVERR);
    for (g = 0; g < 4; g++)
    begin
      d = $urandom();
      axi_wr(8'(eipc_pkg::GROUP0_MASK_ADDR + 4 * g), d, r);
      rchk(8'(eipc_pkg::GROUP0_MASK_ADDR + 4 * g), d & (g == 3 ? 32'h0000_0007 : 32'h0000_00ff), "mask");
    end
    glob <= 1'b1;
    // one sense mode per pin so every pin and every encoding is used
    for (md = 0; md < 4; md++)
    begin
      axi_wr(eipc_pkg::ENABLE_MASK_ADDR, 32'h0000_0000, r);
      axi_wr(eipc_pkg::SENSE_CONTROL_ADDR, md << (2 * md), r);
      axi_wr(eipc_pkg::ENABLE_MASK_ADDR, 1 << md, r);
      ded_cmd[md] <= 1'b0;
      cyc(6);
      ef = (md == 1 || md == 2) ? (1 << md) : 0;
      check("level request", ded_req, (md == 0) ? 1 : ef);
      check("level wake", wake_o, md == 0);
      rchk(eipc_pkg::IRQ_FLAGS_ADDR, ef, "flag after fall");
      ded_cmd[md] <= 1'b1;
      cyc(6);
      ef = (md != 0) ? (1 << md) : 0;
      check("edge request", ded_req, ef);
      rchk(eipc_pkg::IRQ_FLAGS_ADDR, ef, "flag after rise");
      glob <= 1'b0;
      cyc(3);
      check("global gate", ded_req, 4'h0);
      glob <= 1'b1;
      axi_wr(eipc_pkg::IRQ_FLAGS_ADDR, ef, r);
      rchk(eipc_pkg::IRQ_FLAGS_ADDR, 32'h0000_0000, "flag cleared");
    end
    auto_ack <= 1'b1;
    ded_cmd[3] <= 1'b0;
    cyc(2);
    ded_cmd[3] <= 1'b1;
    cyc(8);
    check("acknowledge seen", ack_seen, 32'h0000_0001);
    rchk(eipc_pkg::IRQ_FLAGS_ADDR, 32'h0000_0000, "flag acked");
    auto_ack <= 1'b0;
    axi_wr(eipc_pkg::GROUP_ENABLE_ADDR, 32'h0000_000f, r);
    rchk(eipc_pkg::GROUP_ENABLE_ADDR, 32'h0000_000f, "group enable");
    for (g = 0; g < 4; g++)
    begin
      lo = 8 * g;
      sz = (g == 3) ? 3 : 8;
      p = lo + $urandom() % sz;
      q = lo + (p - lo + 1) % sz;
      axi_wr(8'(eipc_pkg::GROUP0_MASK_ADDR + 4 * g), 1 << (p - lo), r);
      pc_cmd[q] <= ~pc_cmd[q];
      cyc(6);
      rchk(eipc_pkg::GROUP_FLAGS_ADDR, 32'h0000_0000, "masked pin");
      pc_cmd[p] <= ~pc_cmd[p];
      cyc(1);
      #1;
      check("change wake", wake_o, 32'h0000_0001);
      cyc(5);
      check("group request", grp_req, 1 << g);
      rchk(eipc_pkg::GROUP_FLAGS_ADDR, 1 << g, "group flag");
      glob <= 1'b0;
      cyc(3);
      check("group gate", grp_req, 4'h0);
      glob <= 1'b1;
      axi_wr(eipc_pkg::GROUP_FLAGS_ADDR, 1 << g, r);
      rchk(eipc_pkg::GROUP_FLAGS_ADDR, 32'h0000_0000, "group cleared");
    end
    auto_ack <= 1'b1;
    pc_cmd[p] <= ~pc_cmd[p];
    cyc(8);
    rchk(eipc_pkg::GROUP_FLAGS_ADDR, 32'h0000_0000, "group acked");
    check("group ack seen", ack_seen, 32'h0000_0002);
    finish_test();
  end
endmodule
